// ==== core/uetr_core.sv ====
// Overview of operation
// RULE_01 - Request first receive endpoint while its buffer holds at least one byte.
// RULE_02 - Request first transmit endpoint while its buffer holds no data.
// RULE_03 - Request second receive endpoint while its buffer holds at least one byte.
// RULE_04 - Request second transmit endpoint while its buffer holds no data.
// RULE_05 - Controller accesses are bytes only; word and longword are refused.
// RULE_06 - With receive transfers enabled, zero-length packets are dropped without a request.
// RULE_07 - With transfers enabled, software needs no read-done or packet-ready writes.
// RULE_08 - Software still writes packet-ready for a short transmit packet.
// RULE_09 - Receive buffer becomes empty by itself once all data are read.
// RULE_10 - Transmit buffer becomes full and sendable after 64 bytes are written.
// RULE_11 - Read-done happens internally whenever the receive buffer empties, any size.
// RULE_12 - Software must not write read-done while transfers run on that endpoint.
// RULE_13 - A request drops as soon as its condition no longer holds.
`timescale 1ns/100ps
`include "uetr_cfg.svh"
module uetr_core #(
   parameter int EP_BYTES = `UETR_EP_MAX_BYTES,
   parameter int STG_DEPTH = `UETR_STG_DEPTH
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_resetn,
   // Register port
   input wire logic [7:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [31:0] o_reg_rdata,
   // USB receive byte stream
   input wire logic i_usb_rx_valid,
   input wire uetr_pkg::uetr_rx_word_t i_usb_rx,
   output logic o_usb_rx_ready,
   // USB transmit drain, one lane per transmit endpoint
   output logic [1:0] o_usb_tx_valid,
   output logic [1:0][7:0] o_usb_tx_data,
   input wire logic [1:0] i_usb_tx_ready,
   // Data transfer controller
   input wire uetr_pkg::uetr_dtc_cmd_t i_dtc,
   output logic [3:0] o_dtc_req,
   output logic [7:0] o_dtc_rdata,
   output logic o_dtc_rvalid,
   output logic o_dtc_err
);
   localparam int EP_AW = $clog2(EP_BYTES);
   localparam int STG_W = $bits(uetr_pkg::uetr_rx_word_t);

   logic rst_meta_ff, rst_sync_ff;
   logic rst_n;
   logic [3:0] setting_ff, nxt_setting;
   logic size_err_ff, nxt_size_err;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [7:0] dtc_rdata_ff, nxt_dtc_rdata;
   logic dtc_rvalid_ff, nxt_dtc_rvalid, dtc_err_ff, nxt_dtc_err;
   logic [3:0] trig;
   logic [STG_W-1:0] stg_data;
   uetr_pkg::uetr_rx_word_t stg_word;
   logic stg_valid, stg_ready, stg_pop;
   logic [3:0] ep_in_valid, ep_in_ready, ep_out_valid, ep_out_ready;
   logic [3:0][7:0] ep_in_data, ep_out_data;
   logic [3:0][EP_AW:0] ep_count, ep_nxt_count;
   logic [3:0] ep_nxt_valid, ep_flag, ep_flush, ep_pkt_end, ep_req, ep_drain;
   logic byte_size, size_fault, dtc_rd_ok, dtc_rd_hit, dtc_wr_ok;
   logic [1:0] rx_sel;

   // Even endpoint slots receive, odd ones transmit
   function automatic logic is_rx_ep(input logic [1:0] ep);
      return ~ep[0];
   endfunction

   // Reset release through two stages
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_meta_ff <= 1'h0;
         rst_sync_ff <= 1'h0;
      end else begin
         rst_meta_ff <= 1'h1;
         rst_sync_ff <= rst_meta_ff;
      end
   end
   assign rst_n = rst_sync_ff;

   // Receive staging buffer absorbs bursts while the controller lags
   uetr_fifo #(
      .WIDTH(STG_W),
      .DEPTH(STG_DEPTH)
   ) u_stg_fifo (
      .i_mclk(i_mclk),
      .i_rst_n(rst_n),
      .i_flush(1'h0),
      .i_in_valid(i_usb_rx_valid),
      .i_in_data(i_usb_rx),
      .o_in_ready(o_usb_rx_ready),
      .o_out_valid(stg_valid),
      .o_out_data(stg_data),
      .i_out_ready(stg_ready),
      .o_count(),
      .o_nxt_count(),
      .o_nxt_valid()
   );

   // Route staged words; a zero-length marker never needs buffer room
   assign stg_word = uetr_pkg::uetr_rx_word_t'(stg_data);
   assign rx_sel = {stg_word.ep, 1'h0};
   assign stg_ready = stg_word.zlp | ep_in_ready[rx_sel];
   assign stg_pop = stg_valid & stg_ready;

   // Controller access decode; only byte accesses touch a buffer
   assign byte_size = (i_dtc.size == uetr_pkg::UETR_SZ_BYTE); // [RULE_05]
   assign size_fault = (i_dtc.rd | i_dtc.wr) & ~byte_size;
   assign dtc_rd_ok = i_dtc.rd & byte_size & is_rx_ep(i_dtc.ep);
   assign dtc_rd_hit = dtc_rd_ok & ep_out_valid[i_dtc.ep];
   assign dtc_wr_ok = i_dtc.wr & byte_size & ~is_rx_ep(i_dtc.ep) & ep_in_ready[i_dtc.ep];

   // One buffer and one control slice per endpoint
   for (genvar i = 0; i < 4; i++) begin : g_ep
      if (i % 2 == 0) begin : g_rx
         assign ep_in_valid[i] = stg_valid & ~stg_word.zlp & (rx_sel == 2'(i));
         assign ep_in_data[i] = stg_word.data;
         assign ep_out_ready[i] = dtc_rd_hit & (i_dtc.ep == 2'(i));
         // Zero-length packet counts only while transfers are off
         assign ep_pkt_end[i] = stg_pop & (rx_sel == 2'(i)) &
                                (stg_word.zlp ? ~setting_ff[i] : stg_word.last); // [RULE_06]
      end else begin : g_tx
         assign ep_in_valid[i] = dtc_wr_ok & (i_dtc.ep == 2'(i));
         assign ep_in_data[i] = i_dtc.wdata;
         assign ep_out_ready[i] = ep_drain[i] & i_usb_tx_ready[i/2];
         assign ep_pkt_end[i] = 1'h0;
         assign o_usb_tx_valid[i/2] = ep_drain[i];
         assign o_usb_tx_data[i/2] = ep_out_data[i];
      end

      uetr_fifo #(
         .WIDTH(8),
         .DEPTH(EP_BYTES)
      ) u_ep_fifo (
         .i_mclk(i_mclk),
         .i_rst_n(rst_n),
         .i_flush(ep_flush[i]),
         .i_in_valid(ep_in_valid[i]),
         .i_in_data(ep_in_data[i]),
         .o_in_ready(ep_in_ready[i]),
         .o_out_valid(ep_out_valid[i]),
         .o_out_data(ep_out_data[i]),
         .i_out_ready(ep_out_ready[i]),
         .o_count(ep_count[i]),
         .o_nxt_count(ep_nxt_count[i]),
         .o_nxt_valid(ep_nxt_valid[i])
      );

      uetr_ep_ctl #(
         .IS_TX(i % 2 == 1),
         .CW(EP_AW + 1),
         .MAX_BYTES(EP_BYTES)
      ) u_ep_ctl (
         .i_mclk(i_mclk),
         .i_rst_n(rst_n),
         .i_en(setting_ff[i]),
         .i_sw_trig(trig[i]),
         .i_push(ep_in_valid[i] & ep_in_ready[i]),
         .i_pop(ep_out_valid[i] & ep_out_ready[i]),
         .i_pkt_end(ep_pkt_end[i]),
         .i_count(ep_count[i]),
         .i_nxt_count(ep_nxt_count[i]),
         .i_nxt_valid(ep_nxt_valid[i]),
         .o_req(ep_req[i]),
         .o_flag(ep_flag[i]),
         .o_flush(ep_flush[i]),
         .o_drain_valid(ep_drain[i])
      );
   end

   // Register writes and trigger pulses; sticky size error keeps a new fault
   always_comb begin
      trig = 4'h0;
      nxt_setting = setting_ff;
      nxt_size_err = size_fault | size_err_ff;
      if (i_reg_wr) begin
         if (i_reg_addr == `UETR_OFS_SETTING) begin
            nxt_setting = i_reg_wdata[3:0];
         end else if (i_reg_addr == `UETR_OFS_TRIG_ONE) begin
            trig[0] = i_reg_wdata[`UETR_BIT_RD_DONE];
            trig[1] = i_reg_wdata[`UETR_BIT_PKT_READY];
         end else if (i_reg_addr == `UETR_OFS_TRIG_TWO) begin
            trig[2] = i_reg_wdata[`UETR_BIT_RD_DONE];
            trig[3] = i_reg_wdata[`UETR_BIT_PKT_READY];
         end else if (i_reg_addr == `UETR_OFS_STATUS) begin
            if (i_reg_wdata[`UETR_BIT_SIZE_ERR]) begin
               nxt_size_err = size_fault;
            end
         end
      end
   end

   // Register reads; data stand for one cycle only, zero otherwise
   always_comb begin
      nxt_rdata = 32'h0;
      if (i_reg_rd) begin
         if (i_reg_addr == `UETR_OFS_SETTING) begin
            nxt_rdata[3:0] = setting_ff;
         end else if (i_reg_addr == `UETR_OFS_STATUS) begin
            nxt_rdata[`UETR_STS_FLAG_LSB +: 4] = ep_flag;
            nxt_rdata[`UETR_STS_REQ_LSB +: 4] = ep_req;
            nxt_rdata[`UETR_BIT_SIZE_ERR] = size_err_ff;
         end else if (i_reg_addr == `UETR_OFS_COUNT) begin
            for (int k = 0; k < 4; k++) begin
               nxt_rdata[8*k +: 8] = 8'(ep_count[k]);
            end
         end
      end
   end

   // Controller answer; refused accesses leave every buffer untouched
   always_comb begin
      nxt_dtc_rvalid = dtc_rd_hit;
      nxt_dtc_rdata = dtc_rd_hit ? ep_out_data[i_dtc.ep] : 8'h0;
      nxt_dtc_err = (i_dtc.rd & ~dtc_rd_hit) | (i_dtc.wr & ~dtc_wr_ok); // [RULE_05]
   end

   // Registered state of the top
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         setting_ff <= `UETR_SETTING_RST;
         size_err_ff <= 1'h0;
         rdata_ff <= 32'h0;
         dtc_rdata_ff <= 8'h0;
         dtc_rvalid_ff <= 1'h0;
         dtc_err_ff <= 1'h0;
      end else begin
         setting_ff <= nxt_setting;
         size_err_ff <= nxt_size_err;
         rdata_ff <= nxt_rdata;
         dtc_rdata_ff <= nxt_dtc_rdata;
         dtc_rvalid_ff <= nxt_dtc_rvalid;
         dtc_err_ff <= nxt_dtc_err;
      end
   end

   // Port drive
   assign o_reg_rdata = rdata_ff;
   assign o_dtc_req = ep_req;
   assign o_dtc_rdata = dtc_rdata_ff;
   assign o_dtc_rvalid = dtc_rvalid_ff;
   assign o_dtc_err = dtc_err_ff;

   // Zero-length packet with transfers on leaves no trace
   a_zlp_ignored: assert property ( // [RULE_06]
      @(posedge i_mclk) disable iff (!rst_n)
      (stg_pop && stg_word.zlp && !stg_word.ep && setting_ff[0] && !ep_flag[0] &&
       ep_count[0] == '0) |=> (!ep_flag[0] && !o_dtc_req[0]))
      else $error("zero-length packet was not ignored");

   // Wide access is answered by an error and moves no byte
   a_size_refused: assert property ( // [RULE_05]
      @(posedge i_mclk) disable iff (!rst_n)
      ((i_dtc.rd || i_dtc.wr) && !byte_size) |-> (ep_out_ready == 4'h0) &&
      (ep_in_valid[1] == 1'h0) && (ep_in_valid[3] == 1'h0) ##1 (o_dtc_err && !o_dtc_rvalid))
      else $error("non-byte controller access was not refused");

   // Byte read answers in the next cycle with the head byte
   a_rd_answer: assert property ( // [RULE_01]
      @(posedge i_mclk) disable iff (!rst_n)
      dtc_rd_hit |=> (o_dtc_rvalid && o_dtc_rdata == $past(ep_out_data[i_dtc.ep])))
      else $error("controller read not answered one cycle later");

   // Transmit lane is only offered while the endpoint is armed
   a_tx_lane_armed: assert property ( // [RULE_10]
      @(posedge i_mclk) disable iff (!rst_n)
      o_usb_tx_valid[0] |-> ep_flag[1] && ep_count[1] != '0)
      else $error("transmit lane valid while endpoint not armed");

   // Request follows the buffer within one cycle of a change
   a_req_follow: assert property ( // [RULE_13]
      @(posedge i_mclk) disable iff (!rst_n)
      (setting_ff[2] && ep_count[2] == '0 && !ep_in_valid[2]) |=> !o_dtc_req[2])
      else $error("receive request stayed up on an empty buffer");
endmodule

// ==== core/uetr_cfg.svh ====
`ifndef UETR_CFG_SVH
`define UETR_CFG_SVH

// Endpoint buffer size, also the automatic full point of a transmit endpoint
`define UETR_EP_MAX_BYTES 64
// Depth of the receive staging buffer
`define UETR_STG_DEPTH 16

// Register offsets on the plain register port
`define UETR_OFS_SETTING 8'h00
`define UETR_OFS_TRIG_ONE 8'h04
`define UETR_OFS_TRIG_TWO 8'h08
`define UETR_OFS_STATUS 8'h0C
`define UETR_OFS_COUNT 8'h10

// Trigger register fields, same layout in both trigger registers
`define UETR_BIT_RD_DONE 0
`define UETR_BIT_PKT_READY 1

// Status register fields
`define UETR_STS_FLAG_LSB 0
`define UETR_STS_REQ_LSB 4
`define UETR_BIT_SIZE_ERR 8

// Reset value of the transfer setting register
`define UETR_SETTING_RST 4'h0

`endif

// ==== core/uetr_pkg.sv ====
package uetr_pkg;

   // Access size presented by the transfer controller
   typedef enum logic [1:0] {
      UETR_SZ_BYTE,
      UETR_SZ_WORD,
      UETR_SZ_LONG,
      UETR_SZ_RSVD
   } uetr_size_t;

   // One word of the USB receive stream
   typedef struct packed {
      logic ep;
      logic last;
      logic zlp;
      logic [7:0] data;
   } uetr_rx_word_t;

   // One access by the transfer controller
   typedef struct packed {
      logic rd;
      logic wr;
      logic [1:0] ep;
      uetr_size_t size;
      logic [7:0] wdata;
   } uetr_dtc_cmd_t;

endpackage

// ==== core/uetr_fifo.sv ====
`timescale 1ns/100ps
module uetr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int AW = $clog2(DEPTH)
) (
   // Clock and synchronised reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Discard all content
   input wire logic i_flush,
   // Filling side
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   // Draining side
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready,
   // Fill level now and after the coming edge
   output logic [AW:0] o_count,
   output logic [AW:0] o_nxt_count,
   output logic o_nxt_valid
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
   logic [AW:0] mem_cnt_ff, nxt_mem_cnt, count_ff, nxt_count;
   logic out_valid_ff, nxt_out_valid, ready_ff, nxt_ready;
   logic [WIDTH-1:0] out_data_ff, nxt_out_data;
   logic push, pop, load;

   // Head word is held in a register; pointers wrap, so DEPTH is a power of two
   always_comb begin
      push = i_in_valid & ready_ff;
      pop = out_valid_ff & i_out_ready;
      load = (mem_cnt_ff != '0) & (~out_valid_ff | pop);
      nxt_wr_ptr = wr_ptr_ff + AW'(push);
      nxt_rd_ptr = rd_ptr_ff + AW'(load);
      nxt_mem_cnt = mem_cnt_ff + (AW+1)'(push) - (AW+1)'(load);
      nxt_out_valid = load | (out_valid_ff & ~pop);
      nxt_out_data = load ? mem[rd_ptr_ff] : out_data_ff;
      nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
      if (i_flush) begin
         nxt_wr_ptr = '0;
         nxt_rd_ptr = '0;
         nxt_mem_cnt = '0;
         nxt_out_valid = 1'h0;
         nxt_count = '0;
      end
      // Ready is registered so the filling side never sees a combinational path
      nxt_ready = nxt_count < (AW+1)'(DEPTH);
   end

   // Storage array, no reset needed
   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem[wr_ptr_ff] <= i_in_data;
      end
   end

   // Control state
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         mem_cnt_ff <= '0;
         count_ff <= '0;
         out_valid_ff <= 1'h0;
         out_data_ff <= '0;
         ready_ff <= 1'h0;
      end else begin
         wr_ptr_ff <= nxt_wr_ptr;
         rd_ptr_ff <= nxt_rd_ptr;
         mem_cnt_ff <= nxt_mem_cnt;
         count_ff <= nxt_count;
         out_valid_ff <= nxt_out_valid;
         out_data_ff <= nxt_out_data;
         ready_ff <= nxt_ready;
      end
   end

   // Port drive
   assign o_in_ready = ready_ff;
   assign o_out_valid = out_valid_ff;
   assign o_out_data = out_data_ff;
   assign o_count = count_ff;
   assign o_nxt_count = nxt_count;
   assign o_nxt_valid = nxt_out_valid;
endmodule

// ==== core/uetr_ep_ctl.sv ====
`timescale 1ns/100ps
`include "uetr_cfg.svh"
module uetr_ep_ctl #(
   parameter bit IS_TX = 1'h0,
   parameter int CW = 7,
   parameter int MAX_BYTES = `UETR_EP_MAX_BYTES
) (
   // Clock and synchronised reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Software controls
   input wire logic i_en,
   input wire logic i_sw_trig,
   // Buffer activity
   input wire logic i_push,
   input wire logic i_pop,
   input wire logic i_pkt_end,
   input wire logic [CW-1:0] i_count,
   input wire logic [CW-1:0] i_nxt_count,
   input wire logic i_nxt_valid,
   // Results
   output logic o_req,
   output logic o_flag,
   output logic o_flush,
   output logic o_drain_valid
);
   logic req_ff, nxt_req, flag_ff, nxt_flag, drain_ff, nxt_drain;
   logic [CW-1:0] wr_cnt_ff, nxt_wr_cnt;
   logic set_evt, clr_evt, last_out;

   // Flag is packet-present on receive, armed-for-sending on transmit
   always_comb begin
      last_out = i_pop & (i_count == CW'(1)) & ~i_push;
      nxt_wr_cnt = wr_cnt_ff;
      nxt_drain = 1'h0;
      if (IS_TX) begin
         // Full packet arms itself, a short one needs the software trigger
         set_evt = i_sw_trig | (i_en & i_push & ~flag_ff &
                   (wr_cnt_ff == CW'(MAX_BYTES - 1))); // [RULE_07] [RULE_08] [RULE_10]
         clr_evt = flag_ff & (last_out | ((i_count == '0) & ~i_push));
         nxt_flag = set_evt | (flag_ff & ~clr_evt);
         if (set_evt) begin
            nxt_wr_cnt = '0;
         end else if (i_push) begin
            nxt_wr_cnt = wr_cnt_ff + CW'(1);
         end
         // Bytes go to the transmitter only while armed
         nxt_drain = nxt_flag & i_nxt_valid;
         nxt_req = i_en & (i_nxt_count == '0) & ~nxt_flag; // [RULE_02] [RULE_04] [RULE_13]
      end else begin
         set_evt = i_pkt_end;
         // Auto read-done when the last byte leaves, whatever the packet size
         clr_evt = i_sw_trig | (i_en & last_out); // [RULE_09] [RULE_11]
         nxt_flag = set_evt | (flag_ff & ~clr_evt);
         nxt_req = i_en & i_nxt_valid; // [RULE_01] [RULE_03] [RULE_13]
      end
   end

   // Registered results
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         req_ff <= 1'h0;
         flag_ff <= 1'h0;
         drain_ff <= 1'h0;
         wr_cnt_ff <= '0;
      end else begin
         req_ff <= nxt_req;
         flag_ff <= nxt_flag;
         drain_ff <= nxt_drain;
         wr_cnt_ff <= nxt_wr_cnt;
      end
   end

   // Software read-done without transfers discards what is left
   assign o_flush = ~IS_TX & i_sw_trig;
   assign o_req = req_ff;
   assign o_flag = flag_ff;
   assign o_drain_valid = drain_ff;

   if (IS_TX) begin : g_tx_chk
      a_tx_auto_full: assert property ( // [RULE_10]
         @(posedge i_mclk) disable iff (!i_rst_n)
         (i_en && i_push && !flag_ff && wr_cnt_ff == CW'(MAX_BYTES - 1)) |=> flag_ff)
         else $error("transmit endpoint not armed after a full packet");
      a_tx_req_empty: assert property ( // [RULE_02]
         @(posedge i_mclk) disable iff (!i_rst_n)
         o_req |-> (i_count == '0) && !flag_ff)
         else $error("transmit request while buffer holds data");
      a_tx_drain_arm: assert property ( // [RULE_08]
         @(posedge i_mclk) disable iff (!i_rst_n)
         (i_sw_trig && i_count != '0) |=> flag_ff)
         else $error("packet-ready trigger did not arm the endpoint");
   end else begin : g_rx_chk
      a_rx_req_data: assert property ( // [RULE_01]
         @(posedge i_mclk) disable iff (!i_rst_n)
         o_req |-> (i_count != '0))
         else $error("receive request while buffer is empty");
      a_rx_auto_done: assert property ( // [RULE_09]
         @(posedge i_mclk) disable iff (!i_rst_n)
         (i_en && last_out && !i_pkt_end) |=> !flag_ff && !o_req && (i_count == '0))
         else $error("receive endpoint not emptied after last byte");
      a_rx_set_wins: assert property ( // [RULE_11]
         @(posedge i_mclk) disable iff (!i_rst_n)
         (i_pkt_end && i_sw_trig) |=> flag_ff)
         else $error("packet end lost against a read-done");
   end
endmodule

// ==== testbench/uetr_dtc_model.sv ====
`timescale 1ns/100ps
// Far-side transfer controller: one access in flight, then a gap cycle
module uetr_dtc_model (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_resetn,
   // Bench controls
   input wire logic i_run,
   input wire logic i_kick,
   input wire logic [1:0] i_ep,
   input wire logic [6:0] i_len,
   input wire logic [7:0] i_base,
   input wire uetr_pkg::uetr_size_t i_size,
   // Block side
   input wire logic [3:0] i_req,
   input wire logic [7:0] i_rdata,
   input wire logic i_rvalid,
   input wire logic i_err,
   output uetr_pkg::uetr_dtc_cmd_t o_cmd,
   // Results
   output logic o_got,
   output logic [7:0] o_byte,
   output logic [7:0] o_done,
   output logic [7:0] o_nerr
);
   logic [1:0] ph_ff;
   logic [6:0] left_ff;
   logic [7:0] idx_ff;
   // The gap cycle lets a request that fell with the last access be seen low
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         ph_ff <= 2'h0;
         left_ff <= 7'h00;
         idx_ff <= 8'h00;
         o_cmd <= '0;
         o_got <= 1'b0;
         o_done <= 8'h00;
         o_nerr <= 8'h00;
      end else begin
         o_got <= 1'b0;
         case (ph_ff)
            2'h0: begin
               if (left_ff != 7'h00) begin
                  o_cmd.rd <= !i_ep[0];
                  o_cmd.wr <= i_ep[0];
                  o_cmd.ep <= i_ep;
                  o_cmd.size <= i_size; // Byte unless a refusal is wanted
                  o_cmd.wdata <= i_base + idx_ff;
                  ph_ff <= 2'h1;
               end else if (i_kick || (i_run && i_req[i_ep])) begin
                  // Receive: one byte a request; transmit: a whole block
                  left_ff <= (i_ep[0] && !i_kick) ? i_len : 7'h01;
                  idx_ff <= 8'h00;
               end
            end
            2'h1: begin
               o_cmd.rd <= 1'b0;
               o_cmd.wr <= 1'b0;
               o_cmd.wdata <= ~o_cmd.wdata; // Released data never keeps its value
               ph_ff <= 2'h2;
            end
            2'h2: begin
               if (i_err) o_nerr <= o_nerr + 8'h01;
               else o_done <= o_done + 8'h01;
               o_got <= i_rvalid;
               o_byte <= i_rdata;
               left_ff <= left_ff - 7'h01;
               idx_ff <= idx_ff + 8'h01;
               ph_ff <= 2'h3;
            end
            default: ph_ff <= 2'h0;
         endcase
      end
   end
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/100ps
module testbench;
   logic mclk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, rx_v = 1'b0, run = 1'b0;
   logic kick = 1'b0, rx_rdy, rv, er, got;
   logic [7:0] addr = 8'h00, base = 8'h00, rdt, gb, done, nerr;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0] tx_v, tx_rdy = 2'h0, ep = 2'h0;
   logic [1:0][7:0] tx_d;
   logic [6:0] len = 7'h01;
   logic [3:0] req;
   uetr_pkg::uetr_rx_word_t rx = '0;
   uetr_pkg::uetr_size_t size = uetr_pkg::UETR_SZ_BYTE;
   uetr_pkg::uetr_dtc_cmd_t cmd;
   int n_mismatch = 0, comparisons = 0, cyc = 0;
   logic [7:0] q[$];

   uetr_core uut (.i_mclk(mclk), .i_resetn(resetn), .i_reg_addr(addr), .i_reg_wdata(wdata),
      .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_usb_rx_valid(rx_v),
      .i_usb_rx(rx), .o_usb_rx_ready(rx_rdy), .o_usb_tx_valid(tx_v), .o_usb_tx_data(tx_d),
      .i_usb_tx_ready(tx_rdy), .i_dtc(cmd), .o_dtc_req(req), .o_dtc_rdata(rdt),
      .o_dtc_rvalid(rv), .o_dtc_err(er));
   uetr_dtc_model dtc (.i_mclk(mclk), .i_resetn(resetn), .i_run(run), .i_kick(kick),
      .i_ep(ep), .i_len(len), .i_base(base), .i_size(size), .i_req(req), .i_rdata(rdt),
      .i_rvalid(rv), .i_err(er), .o_cmd(cmd), .o_got(got), .o_byte(gb), .o_done(done),
      .o_nerr(nerr));

   // Clock, captured read bytes and the hang guard
   always #5 mclk = ~mclk;
   always @(posedge mclk) if (got) q.push_back(gb);
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         end_of_test;
      end
   end

   task chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Register port cycles: strobes last one cycle, read data stand the cycle after
   task wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(posedge mclk);
      chk(rdata, e);
   endtask
   task wreq(input int n, input logic v);
      int t;
      t = 0;
      while (req[n] !== v && t < 300) begin
         @(posedge mclk);
         t++;
      end
      chk(32'(req[n]), 32'(v));
   endtask
   task wdone(input logic [7:0] tg);
      int t;
      t = 0;
      while (done !== tg && t < 2000) begin
         @(posedge mclk);
         t++;
      end
      chk(32'(done), 32'(tg));
   endtask
   // Receive stream: each word held until an edge sees ready high
   task send_rx(input int k, input logic z, input int n, input logic [7:0] b);
      @(posedge mclk);
      for (int i = 0; i < n; i++) begin
         rx_v <= 1'b1;
         rx <= '{ep: k[0], last: (i == n - 1), zlp: z, data: b + 8'(i)};
         do @(posedge mclk); while (rx_rdy !== 1'b1);
      end
      rx_v <= 1'b0;
      rx.data <= ~rx.data;
   endtask
   // Transmit lane drain with the transmitter stalling every third cycle
   task drain(input int k, input int n, input logic [7:0] b);
      int i, t;
      i = 0;
      t = 0;
      while (i < n && t < 1000) begin
         @(posedge mclk);
         if (tx_rdy[k] && tx_v[k]) begin
            chk(32'(tx_d[k]), 32'(b + 8'(i)));
            i++;
         end
         if (i < n) tx_rdy[k] <= (t % 3 != 2);
         else tx_rdy[k] <= 1'b0;
         t++;
      end
      chk(i, n);
   endtask

   task reg_test;
      rchk(8'h00, 32'h0);
      rchk(8'h20, 32'h0);
      wreg(8'h20, 32'hFFFFFFFF);
      rchk(8'h20, 32'h0);
      wreg(8'h00, 32'hF);
      rchk(8'h00, 32'hF);
      rchk(8'h04, 32'h0);
      wreg(8'h00, 32'h0);
      $display("register test done");
   endtask
   task size_test;
      ep <= 2'h1;
      size <= uetr_pkg::UETR_SZ_WORD;
      kick <= 1'b1;
      @(posedge mclk);
      kick <= 1'b0;
      repeat (6) @(posedge mclk);
      size <= uetr_pkg::UETR_SZ_BYTE;
      chk(32'(nerr), 32'h1);
      rchk(8'h0C, 32'h100);
      wreg(8'h0C, 32'h100);
      rchk(8'h0C, 32'h0);
      $display("size test done");
   endtask
   // Read-done is never written while transfers run
   task rx_test(input int k);
      int e;
      logic [7:0] b, d0, e0;
      e = 2 * k;
      b = 8'hA0 + 8'(k);
      d0 = done;
      e0 = nerr;
      wreg(8'h00, 32'h1 << e);
      send_rx(k, 1'b0, 3, b);
      wreq(e, 1'b1);
      ep <= 2'(e);
      run <= 1'b1;
      wdone(d0 + 8'h03);
      run <= 1'b0;
      // Let the capture of the last byte land before the queue is read
      @(posedge mclk);
      for (int i = 0; i < 3; i++) chk(32'(q.pop_front()), 32'(b + 8'(i)));
      wreq(e, 1'b0);
      rchk(8'h0C, 32'h0);
      rchk(8'h10, 32'h0);
      send_rx(k, 1'b1, 1, 8'h00);
      repeat (8) @(posedge mclk);
      chk(32'(req[e]), 32'h0);
      rchk(8'h0C, 32'h0);
      chk(32'(nerr), 32'(e0));
      // A read of the now empty endpoint is refused and returns no byte
      kick <= 1'h1;
      @(posedge mclk);
      kick <= 1'h0;
      repeat (6) @(posedge mclk);
      chk(32'(nerr), 32'(e0 + 8'h01));
      chk(q.size(), 0);
      $display("receive test %0d done", k);
   endtask
   task tx_test(input int k);
      int e;
      logic [7:0] b, d0;
      e = 2 * k + 1;
      b = 8'h30 + 8'(k * 16);
      wreg(8'h00, 32'h1 << e);
      wreq(e, 1'b1);
      d0 = done;
      ep <= 2'(e);
      len <= 7'h40;
      base <= b;
      run <= 1'b1;
      wdone(d0 + 8'h40); // No packet-ready write here
      run <= 1'b0;
      repeat (2) @(posedge mclk);
      chk(32'(req[e]), 32'h0);
      chk(32'(tx_v[k]), 32'h1);
      rchk(8'h10, 32'h40 << (8 * e));
      drain(k, 64, b);
      wreq(e, 1'b1);
      len <= 7'h03;
      run <= 1'b1;
      wdone(d0 + 8'h43);
      run <= 1'b0;
      repeat (4) @(posedge mclk);
      chk(32'(tx_v[k]), 32'h0);
      wreg(k ? 8'h08 : 8'h04, 32'h2);
      drain(k, 3, b);
      $display("transmit test %0d done", k);
   endtask

   task end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Reset for eight cycles, then settle before the first access
   initial begin
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;
      repeat (4) @(posedge mclk);
      reg_test;
      size_test;
      rx_test(0);
      rx_test(1);
      tx_test(0);
      tx_test(1);
      end_of_test;
   end
endmodule
